// >>> acs_pkg.sv
// constants and types for the converter cycle and serial port
package acs_pkg;
    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int CONV_SLOW_NS  = 4_000_000;
    localparam int CONV_FAST_NS  = 1_000_000;
    localparam int POR_NS        = 500_000;
    localparam int CONV_SLOW_CYC = CONV_SLOW_NS / CLK_PERIOD_NS;
    localparam int CONV_FAST_CYC = CONV_FAST_NS / CLK_PERIOD_NS;
    localparam int POR_CYC       = POR_NS / CLK_PERIOD_NS;

    // widths
    localparam int CNT_W    = 20;
    localparam int RES_W    = 16;
    localparam int SAMPLE_W = 18;
    localparam int FCNT_W   = 5;
    localparam int RCNT_W   = 3;
    localparam int PROG_W   = 4;

    // serial frame
    localparam logic [FCNT_W-1:0] FRAME_BITS = 5'h10;
    localparam logic [FCNT_W-1:0] FRAME_GRAY = 5'h18;
    localparam logic [RCNT_W-1:0] PROG_LEN   = 3'h4;
    localparam logic [1:0]        PROG_KEY   = 2'h2;
    localparam logic [PROG_W-1:0] TIED_LOW   = 4'h0;
    localparam logic [PROG_W-1:0] TIED_HIGH  = 4'hF;
    localparam int KEY_HI_POS = 3;
    localparam int KEY_LO_POS = 2;
    localparam int RATE_POS   = 1;
    localparam int REFPD_POS  = 0;

    // defaults
    localparam logic RATE_DEFAULT  = 1'b0;
    localparam logic REFPD_DEFAULT = 1'b0;

    // result coding
    localparam logic signed [SAMPLE_W:0] CODE_MID  = 19'sh08000;
    localparam logic signed [SAMPLE_W:0] CODE_TOP  = 19'sh0FFFF;
    localparam logic [RES_W-1:0]         CODE_ONES = 16'hFFFF;
    localparam logic [RES_W-1:0]         CODE_ZERO = 16'h0000;

    typedef enum logic [1:0] {
        ST_POR       = 2'h0,
        ST_CONVERT   = 2'h1,
        ST_POWERDOWN = 2'h3,
        ST_DATA_IO   = 2'h2
    } acs_state_e;

    typedef struct packed {
        acs_state_e              state;
        logic [CNT_W-1:0]        cnt;
        logic                    adc_on;
        logic                    ref_on;
        logic                    rate;
        logic                    refpd;
        logic [RES_W-1:0]        hold;
        logic                    sout;
        logic                    oe;
        logic                    link_rst;
        logic                    cs_meta;
        logic                    cs_sync;
        logic [FCNT_W-1:0]       fg_meta;
        logic [FCNT_W-1:0]       fg_sync;
        logic [RCNT_W+PROG_W-1:0] pg_meta;
        logic [RCNT_W+PROG_W-1:0] pg_sync;
    } acs_sys_s;

    typedef struct packed {
        logic [RCNT_W-1:0] rcnt;
        logic [PROG_W-1:0] bits;
    } acs_rise_s;

    typedef struct packed {
        logic [FCNT_W-1:0] fbin;
        logic [FCNT_W-1:0] fgray;
    } acs_fall_s;

    localparam acs_sys_s SYS_RESET = '{
        state: ST_POR, cnt: '0, adc_on: 1'b0, ref_on: 1'b1,
        rate: RATE_DEFAULT, refpd: REFPD_DEFAULT, hold: '0,
        sout: 1'b0, oe: 1'b0, link_rst: 1'b1, cs_meta: 1'b1,
        cs_sync: 1'b1, fg_meta: '0, fg_sync: '0, pg_meta: '0, pg_sync: '0};
endpackage

// >>> acs_top.sv
// converter cycle sequencer and serial result/programming port
//
// Behaviour
// (RQ1) cycle convert, then powerdown, then data I/O; start in convert
// (RQ2) conversion lasts 4 ms at slow rate, 1 ms at fast rate
// (RQ3) a started conversion always completes; only power-on reset ends it
// (RQ4) after conversion hold result in powerdown until chip select low
// (RQ5) light powerdown: converter off, reference kept on
// (RQ6) deep powerdown: reference and converter off; reference on at chip select low
// (RQ7) entering data I/O presents the sign bit at once
// (RQ8) each serial clock fall presents the next bit, MSB first
// (RQ9) host captures result bits on serial clock rise
// (RQ10) serial data-in sampled on serial clock rise; host sends 4-bit word
// (RQ11) settings taken only when key bits are 1 then 0
// (RQ12) rate select 0 gives 208 sps, 1 gives 833 sps
// (RQ13) reference powerdown 1 turns reference off after next conversion
// (RQ14) the 12 data-in bits after the word are ignored
// (RQ15) data-in tied low gives slow rate, tied high fast; no deep powerdown
// (RQ16) 16th serial clock fall ends data I/O and starts conversion
// (RQ17) chip select rising in data I/O aborts and starts conversion
// (RQ18) power-on reset lasts 0.5 ms and restores default settings
// (RQ19) after power-on reset a conversion starts
// (RQ20) host discards the first conversion after power-up
// (RQ21) single-ended code is straight binary clamped to 0 and all ones
// (RQ22) differential code is offset binary around 32768, clamped
// (RQ23) chip select high: output released, serial clock and data ignored
// (RQ24) first word bit is the first serial clock rise after conversion
// (RQ25) host waits the conversion time before lowering chip select
// (RQ26) host keeps serial clock quiet during conversion
`timescale 1ns/1ps
`default_nettype none
module acs_top
    import acs_pkg::*;
#(
    parameter int CONV_SLOW_CYCLES = CONV_SLOW_CYC,
    parameter int CONV_FAST_CYCLES = CONV_FAST_CYC,
    parameter int POR_CYCLES       = POR_CYC
) (
    input  wire logic                CLK_SYS,
    input  wire logic                RST,
    input  wire logic                SCK,
    input  wire logic                CS_N,
    input  wire logic                SERIAL_IN,
    output logic                     SERIAL_OUT,
    output logic                     SERIAL_OUT_EN,
    input  wire logic [SAMPLE_W-1:0] SAMPLE_IN,
    input  wire logic                DIFF_MODE,
    output logic                     ADC_POWER_ON,
    output logic                     REF_POWER_ON,
    output logic                     RATE_SELECT,
    output logic                     REFERENCE_POWERDOWN
);

    function automatic logic [RES_W-1:0] clamp_code(input logic [SAMPLE_W-1:0] s,
                                                    input logic diff);
        logic signed [SAMPLE_W:0] v;
        v = signed'({s[SAMPLE_W-1], s});
        if (diff) begin
            v = v + CODE_MID;
        end
        if (v < 0) begin
            return CODE_ZERO;
        end else if (v > CODE_TOP) begin
            return CODE_ONES;
        end
        return v[RES_W-1:0];
    endfunction

    function automatic logic [FCNT_W-1:0] gray2bin(input logic [FCNT_W-1:0] g);
        logic [FCNT_W-1:0] b;
        b[FCNT_W-1] = g[FCNT_W-1];
        for (int i = FCNT_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    acs_sys_s  st_r;
    acs_sys_s  st_nxt;
    acs_rise_s rs_r;
    acs_rise_s rs_nxt;
    acs_fall_s fl_r;
    acs_fall_s fl_nxt;

    logic [CNT_W-1:0]  conv_last;
    logic [CNT_W-1:0]  por_last;
    logic [FCNT_W-1:0] fbin_sync;
    logic [3:0]        bit_idx;
    logic              frame_done;
    logic [RCNT_W-1:0] prog_cnt;
    logic [PROG_W-1:0] prog_bits;

    assign conv_last  = st_r.rate ? CNT_W'(CONV_FAST_CYCLES - 1)
                                  : CNT_W'(CONV_SLOW_CYCLES - 1); // RQ2 RQ12
    assign por_last   = CNT_W'(POR_CYCLES - 1);
    assign fbin_sync  = gray2bin(st_r.fg_sync);
    assign bit_idx    = fbin_sync[3:0];
    assign frame_done = (st_r.fg_sync == FRAME_GRAY);
    assign prog_cnt   = st_r.pg_sync[RCNT_W+PROG_W-1:PROG_W];
    assign prog_bits  = st_r.pg_sync[PROG_W-1:0];

    // system clock domain: sequencer, result register, settings
    always_comb begin
        st_nxt         = st_r;
        st_nxt.cs_meta = CS_N;
        st_nxt.cs_sync = st_r.cs_meta;
        st_nxt.fg_meta = fl_r.fgray;
        st_nxt.fg_sync = st_r.fg_meta;
        st_nxt.pg_meta = {rs_r.rcnt, rs_r.bits};
        st_nxt.pg_sync = st_r.pg_meta;
        unique case (st_r.state)
            ST_POR: begin
                if (st_r.cnt == por_last) begin // RQ18
                    st_nxt.state  = ST_CONVERT; // RQ19 RQ1
                    st_nxt.cnt    = '0;
                    st_nxt.adc_on = 1'b1;
                end else begin
                    st_nxt.cnt = st_r.cnt + 1'b1;
                end
            end
            ST_CONVERT: begin
                // serial port is not looked at here
                if (st_r.cnt == conv_last) begin // RQ3
                    st_nxt.state  = ST_POWERDOWN; // RQ4
                    st_nxt.cnt    = '0;
                    st_nxt.adc_on = 1'b0; // RQ5
                    st_nxt.ref_on = !st_r.refpd; // RQ6 RQ13
                    st_nxt.hold   = clamp_code(SAMPLE_IN, DIFF_MODE); // RQ21 RQ22
                end else begin
                    st_nxt.cnt = st_r.cnt + 1'b1;
                end
            end
            ST_POWERDOWN: begin
                if (!st_r.cs_sync) begin // RQ4
                    st_nxt.state    = ST_DATA_IO;
                    st_nxt.ref_on   = 1'b1; // RQ6
                    st_nxt.oe       = 1'b1;
                    st_nxt.sout     = st_r.hold[RES_W-1]; // RQ7
                    st_nxt.link_rst = 1'b0; // RQ24
                end
            end
            ST_DATA_IO: begin
                st_nxt.sout = st_r.hold[~bit_idx]; // RQ8
                if (st_r.cs_sync || frame_done) begin // RQ16 RQ17
                    st_nxt.state    = ST_CONVERT;
                    st_nxt.adc_on   = 1'b1;
                    st_nxt.oe       = 1'b0; // RQ23
                    st_nxt.link_rst = 1'b1;
                    // later data-in bits never reach the word
                    if (prog_cnt == PROG_LEN) begin // RQ14
                        if (prog_bits[KEY_HI_POS:KEY_LO_POS] == PROG_KEY) begin // RQ11
                            st_nxt.rate  = prog_bits[RATE_POS];
                            st_nxt.refpd = prog_bits[REFPD_POS];
                        end else if (prog_bits == TIED_HIGH) begin // RQ15
                            st_nxt.rate  = 1'b1;
                            st_nxt.refpd = 1'b0;
                        end else if (prog_bits == TIED_LOW) begin // RQ15
                            st_nxt.rate  = 1'b0;
                            st_nxt.refpd = 1'b0;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            st_r <= SYS_RESET; // RQ18
        end else begin
            st_r <= st_nxt;
        end
    end

    // link domain, rising edge: programming word capture
    always_comb begin
        rs_nxt = rs_r;
        if (rs_r.rcnt != PROG_LEN) begin // RQ14
            rs_nxt.rcnt = rs_r.rcnt + 1'b1;
            rs_nxt.bits = {rs_r.bits[PROG_W-2:0], SERIAL_IN}; // RQ10
        end
    end

    always_ff @(posedge SCK or posedge st_r.link_rst) begin
        if (st_r.link_rst) begin
            rs_r <= '0; // RQ23
        end else begin
            rs_r <= rs_nxt;
        end
    end

    // link domain, falling edge: bit position, gray coded for the crossing
    always_comb begin
        fl_nxt = fl_r;
        if (fl_r.fbin != FRAME_BITS) begin
            fl_nxt.fbin  = fl_r.fbin + 1'b1; // RQ8
            fl_nxt.fgray = fl_nxt.fbin ^ (fl_nxt.fbin >> 1);
        end
    end

    always_ff @(negedge SCK or posedge st_r.link_rst) begin
        if (st_r.link_rst) begin
            fl_r <= '0;
        end else begin
            fl_r <= fl_nxt;
        end
    end

    assign SERIAL_OUT          = st_r.sout;
    assign SERIAL_OUT_EN       = st_r.oe;
    assign ADC_POWER_ON        = st_r.adc_on;
    assign REF_POWER_ON        = st_r.ref_on;
    assign RATE_SELECT         = st_r.rate;
    assign REFERENCE_POWERDOWN = st_r.refpd;

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);

    property p_order;
        $changed(st_r.state) |->
            (st_r.state == ST_CONVERT && $past(st_r.state) inside {ST_POR, ST_DATA_IO}) ||
            (st_r.state == ST_POWERDOWN && $past(st_r.state) == ST_CONVERT) ||
            (st_r.state == ST_DATA_IO && $past(st_r.state) == ST_POWERDOWN);
    endproperty
    a_order: assert property (p_order) else $error("illegal state order"); // RQ1

    property p_por_end;
        st_r.state == ST_POR && st_r.cnt == por_last |=> st_r.state == ST_CONVERT && ADC_POWER_ON;
    endproperty
    a_por_end: assert property (p_por_end) else $error("no conversion after reset"); // RQ19

    property p_conv_len;
        st_r.state == ST_CONVERT && st_r.cnt == conv_last |=> st_r.state == ST_POWERDOWN;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion length wrong"); // RQ2

    property p_conv_hold;
        st_r.state == ST_CONVERT && st_r.cnt != conv_last |=> st_r.state == ST_CONVERT;
    endproperty
    a_conv_hold: assert property (p_conv_hold) else $error("conversion cut short"); // RQ3

    property p_pd_wait;
        st_r.state == ST_POWERDOWN && st_r.cs_sync |=> st_r.state == ST_POWERDOWN && $stable(st_r.hold);
    endproperty
    a_pd_wait: assert property (p_pd_wait) else $error("powerdown left early"); // RQ4

    property p_light;
        st_r.state == ST_POWERDOWN && !st_r.refpd |-> REF_POWER_ON && !ADC_POWER_ON;
    endproperty
    a_light: assert property (p_light) else $error("light powerdown power wrong"); // RQ5

    property p_deep;
        (st_r.state == ST_POWERDOWN && st_r.refpd |-> !REF_POWER_ON && !ADC_POWER_ON) and
        (st_r.state == ST_DATA_IO |-> REF_POWER_ON);
    endproperty
    a_deep: assert property (p_deep) else $error("deep powerdown power wrong"); // RQ6

    property p_sign;
        $rose(SERIAL_OUT_EN) |-> SERIAL_OUT == st_r.hold[RES_W-1];
    endproperty
    a_sign: assert property (p_sign) else $error("sign bit not first"); // RQ7

    property p_shift;
        st_r.state == ST_DATA_IO && $past(st_r.state) == ST_DATA_IO |->
            SERIAL_OUT == st_r.hold[~$past(bit_idx)];
    endproperty
    a_shift: assert property (p_shift) else $error("wrong result bit out"); // RQ8

    property p_prog;
        $changed(RATE_SELECT) || $changed(REFERENCE_POWERDOWN) |->
            $past(st_r.state) == ST_DATA_IO && $past(prog_cnt) == PROG_LEN;
    endproperty
    a_prog: assert property (p_prog) else $error("setting changed without word"); // RQ11

    property p_done;
        st_r.state == ST_DATA_IO && frame_done |=> st_r.state == ST_CONVERT && ADC_POWER_ON;
    endproperty
    a_done: assert property (p_done) else $error("frame end missed"); // RQ16

    property p_abort;
        st_r.state == ST_DATA_IO && st_r.cs_sync |=> st_r.state == ST_CONVERT && !SERIAL_OUT_EN;
    endproperty
    a_abort: assert property (p_abort) else $error("abort missed"); // RQ17

    property p_hiz;
        st_r.state != ST_DATA_IO |-> !SERIAL_OUT_EN;
    endproperty
    a_hiz: assert property (p_hiz) else $error("output driven outside data I/O"); // RQ23

    property p_code;
        $rose(st_r.state == ST_POWERDOWN) |->
            st_r.hold == clamp_code($past(SAMPLE_IN), $past(DIFF_MODE));
    endproperty
    a_code: assert property (p_code) else $error("result code wrong"); // RQ21 RQ22

    property p_reset;
        @(posedge CLK_SYS) disable iff (1'b0)
            RST |=> st_r.state == ST_POR && !RATE_SELECT && !REFERENCE_POWERDOWN;
    endproperty
    a_reset: assert property (p_reset) else $error("reset defaults wrong"); // RQ18

    property p_fast_len;
        st_r.state == ST_CONVERT && st_r.rate && st_r.cnt == CNT_W'(CONV_FAST_CYCLES - 1)
            |=> st_r.state == ST_POWERDOWN;
    endproperty
    a_fast_len: assert property (p_fast_len) else $error("fast conversion length wrong"); // RQ12

    // link flops stay cleared whenever no transfer may run
    property p_link_idle;
        st_r.state != ST_DATA_IO |-> st_r.link_rst;
    endproperty
    a_link_idle: assert property (p_link_idle) else $error("link active outside data I/O"); // RQ23

    // word frozen once four bits are in
    property p_word_frozen;
        st_r.state == ST_DATA_IO && prog_cnt == PROG_LEN |=>
            st_r.state != ST_DATA_IO || $stable(prog_bits);
    endproperty
    a_word_frozen: assert property (p_word_frozen) else $error("word changed after 4 bits"); // RQ14

    c_deep:  cover property (st_r.state == ST_POWERDOWN && st_r.refpd);
    c_tied:  cover property (st_r.state == ST_DATA_IO && prog_cnt == PROG_LEN &&
                             prog_bits == TIED_HIGH);
    c_abort: cover property (st_r.state == ST_DATA_IO && st_r.cs_sync && !frame_done);
    c_done:  cover property (st_r.state == ST_DATA_IO && frame_done);
    c_fast:  cover property ($rose(RATE_SELECT));

endmodule
`default_nettype wire

// >>> acs_host.sv
// serial host model: chip select, serial clock and data-in
`timescale 1ns/1ps
`default_nettype none
module acs_host (
    output logic      SCK,
    output logic      CS_N,
    output logic      SERIAL_IN,
    input  wire logic SERIAL_OUT,
    input  wire logic SERIAL_OUT_EN
);
    initial begin
        SCK       = 1'b0;
        CS_N      = 1'b1;
        SERIAL_IN = 1'b0;
    end
    // caller waits the conversion time first
    task automatic cs_low();
        #3 CS_N = 1'b0;
        #200;
    endtask
    task automatic xfer(input logic [15:0] serial_in, input int n, output logic [15:0] got,
                        output logic en_ok);
        got   = '0;
        en_ok = 1'b1;
        for (int i = 0; i < n; i++) begin
            SERIAL_IN = serial_in[15-i];
            #80 SCK = 1'b1;
            got[15-i] = SERIAL_OUT;
            en_ok &= SERIAL_OUT_EN;
            #80 SCK = 1'b0;
        end
        #200;
    endtask
    // released data-in no longer shows the old level
    task automatic cs_high();
        CS_N      = 1'b1;
        SERIAL_IN = ~SERIAL_IN;
        #20;
    endtask
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking bench for the converter cycle and serial port
`timescale 1ns/1ps
`default_nettype none
module tb;
    import acs_pkg::*;
    localparam int SLOW = 400;
    localparam int FAST = 100;
    localparam int PORC = 50;
    logic                CLK_SYS, RST, SCK, CS_N, SERIAL_IN, SERIAL_OUT, SERIAL_OUT_EN;
    logic                DIFF_MODE, ADC_POWER_ON, REF_POWER_ON, RATE_SELECT;
    logic                REFERENCE_POWERDOWN;
    logic [SAMPLE_W-1:0] SAMPLE_IN;
    logic [15:0]         got;
    logic                en_ok;
    int                  err_total = 0;
    int                  n_tests = 0;
    int                  n;
    int                  conv_cyc = 0;

    acs_top #(.CONV_SLOW_CYCLES(SLOW), .CONV_FAST_CYCLES(FAST), .POR_CYCLES(PORC)) u_dut (
        .CLK_SYS(CLK_SYS), .RST(RST), .SCK(SCK), .CS_N(CS_N), .SERIAL_IN(SERIAL_IN),
        .SERIAL_OUT(SERIAL_OUT), .SERIAL_OUT_EN(SERIAL_OUT_EN), .SAMPLE_IN(SAMPLE_IN),
        .DIFF_MODE(DIFF_MODE), .ADC_POWER_ON(ADC_POWER_ON), .REF_POWER_ON(REF_POWER_ON),
        .RATE_SELECT(RATE_SELECT), .REFERENCE_POWERDOWN(REFERENCE_POWERDOWN));
    acs_host u_host (.SCK(SCK), .CS_N(CS_N), .SERIAL_IN(SERIAL_IN),
        .SERIAL_OUT(SERIAL_OUT), .SERIAL_OUT_EN(SERIAL_OUT_EN));

    initial begin
        CLK_SYS = 1'b0;
        forever #4 CLK_SYS = ~CLK_SYS;
    end

    // cycles seen so far in the running conversion
    always @(negedge CLK_SYS) begin
        conv_cyc <= ADC_POWER_ON ? conv_cyc + 1 : 0;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wait_adc(input logic v, output int cyc);
        // a conversion may already have run for a while
        cyc = (v == 1'b0) ? conv_cyc : 0;
        while (ADC_POWER_ON !== v) begin
            @(negedge CLK_SYS);
            cyc++;
            if (cyc > 2000) begin
                chk("adc wait", 0, 1);
                test_done();
            end
        end
    endtask
    task automatic near(input string what, input int seen, input int exp);
        chk(what, (seen >= exp - 2 && seen <= exp + 2) ? exp : seen, exp);
    endtask
    // one transfer of nb clocks; conversion must follow
    task automatic rd(input logic [15:0] serial_in, input int nb);
        u_host.cs_low();
        chk("ref on when selected", REF_POWER_ON, 1'b1);
        u_host.xfer(serial_in, nb, got, en_ok);
        chk("out driven", en_ok, 1'b1);
        u_host.cs_high();
        @(negedge CLK_SYS);
        wait_adc(1'b1, n);
        chk("restart", n <= 8, 1);
        chk("out released", SERIAL_OUT_EN, 1'b0);
    endtask

    task automatic t_reset();
        repeat (6) @(negedge CLK_SYS);
        chk("reset en", SERIAL_OUT_EN, 1'b0);
        chk("reset adc", ADC_POWER_ON, 1'b0);
        chk("reset ref", REF_POWER_ON, 1'b1);
        chk("reset rate", RATE_SELECT, RATE_DEFAULT);
        chk("reset refpd", REFERENCE_POWERDOWN, REFPD_DEFAULT);
        RST = 1'b0;
        wait_adc(1'b1, n);
        near("por length", n, PORC);
        wait_adc(1'b0, n);
        near("slow conv", n, SLOW);
        $display("test reset done");
    endtask
    task automatic t_abort();
        rd(16'hB000, 1);
        chk("sign bit", got[15], 1'b1);
        chk("partial word rate", RATE_SELECT, 1'b0);
        wait_adc(1'b0, n);
        near("conv after abort", n, SLOW);
        $display("test abort done");
    endtask
    task automatic t_prog();
        rd(16'hB5A5, 16);
        chk("result", got, 16'hC0A5);
        chk("rate fast", RATE_SELECT, 1'b1);
        chk("deep set", REFERENCE_POWERDOWN, 1'b1);
        DIFF_MODE = 1'b1;
        SAMPLE_IN = 18'h3FFFF;
        wait_adc(1'b0, n);
        near("fast conv", n, FAST);
        repeat (20) @(negedge CLK_SYS);
        chk("deep ref off", REF_POWER_ON, 1'b0);
        chk("stays idle", ADC_POWER_ON, 1'b0);
        $display("test program done");
    endtask
    task automatic t_reject();
        rd(16'h4FFF, 16);
        chk("diff minus one", got, 16'h7FFF);
        chk("rate kept", RATE_SELECT, 1'b1);
        chk("deep kept", REFERENCE_POWERDOWN, 1'b1);
        DIFF_MODE = 1'b0;
        SAMPLE_IN = 18'h1FFFF;
        wait_adc(1'b0, n);
        near("fast conv kept", n, FAST);
        $display("test reject done");
    endtask
    task automatic t_static();
        rd(16'h0000, 16);
        chk("clamp top", got, 16'hFFFF);
        chk("tied low rate", RATE_SELECT, 1'b0);
        chk("tied low deep", REFERENCE_POWERDOWN, 1'b0);
        DIFF_MODE = 1'b1;
        SAMPLE_IN = 18'h363C0;
        wait_adc(1'b0, n);
        near("slow again", n, SLOW);
        chk("light ref on", REF_POWER_ON, 1'b1);
        rd(16'hFFFF, 16);
        chk("clamp bottom", got, 16'h0000);
        chk("tied high rate", RATE_SELECT, 1'b1);
        chk("tied high deep", REFERENCE_POWERDOWN, 1'b0);
        wait_adc(1'b0, n);
        near("fast from tie", n, FAST);
        $display("test static done");
    endtask

    initial begin
        RST       = 1'b1;
        DIFF_MODE = 1'b0;
        SAMPLE_IN = 18'h0C0A5;
        @(negedge CLK_SYS);
        t_reset();
        t_abort();
        t_prog();
        t_reject();
        t_static();
        test_done();
    end
endmodule
`default_nettype wire
